// >>> core/sfwl_port.sv
// one serial frequency port: shift register, down-counter, holding register
`timescale 1ns/100ps
module sfwl_port (
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       clk_en_in,
  input  wire logic [sfwl_pkg::WLEN_W-1:0] word_len_in,
  input  wire logic                       ser_data_in,
  input  wire logic                       word_sync_in,
  output logic [sfwl_pkg::WORD_W-1:0]     hold_word_out,
  output logic                            word_load_out,
  output logic                            busy_out
);
  import sfwl_pkg::*;

  sfwl_state_e           state;
  logic [CNT_W-1:0]      bit_cnt;
  logic [WORD_W-1:0]     shift_reg;
  logic [CNT_W-1:0]      next_bit_cnt;

  // programmed length in bits: (sel+1)*8
  always_comb begin
    next_bit_cnt = BITS_PER_STEP * ({4'h0, word_len_in} + 6'h01);
  end

  // sync loads the counter, then one bit per clock until it runs out
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state   <= SFWL_IDLE;
      bit_cnt <= CNT_RST;
    end else if (clk_en_in) begin
      case (state)
        SFWL_IDLE: begin
          if (word_sync_in) begin // R5
            state   <= SFWL_SHIFT;
            bit_cnt <= next_bit_cnt;
          end
        end
        SFWL_SHIFT: begin
          bit_cnt <= bit_cnt - 6'h01;
          if (bit_cnt == 6'h01) begin
            state <= SFWL_XFER; // R6
          end
        end
        SFWL_XFER: begin
          // shifter back in service the cycle after the transfer
          state <= SFWL_IDLE; // R7
        end
        default: begin
          state <= SFWL_IDLE;
        end
      endcase
    end
  end

  // msb-first data enters at bit 0 and walks upward
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shift_reg <= SHIFT_RST;
    end else if (clk_en_in) begin
      if (state == SFWL_IDLE && word_sync_in) begin
        shift_reg <= SHIFT_RST;
      end else if (state == SFWL_SHIFT) begin
        shift_reg <= {shift_reg[WORD_W-2:0], ser_data_in}; // R3 R9
      end
    end
  end

  // left-justify short words, low bits zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hold_word_out <= HOLD_RST;
      word_load_out <= 1'b0;
    end else if (clk_en_in) begin
      word_load_out <= (state == SFWL_XFER);
      if (state == SFWL_XFER) begin
        case (word_len_in)
          WLEN_8:  hold_word_out <= {shift_reg[7:0], 24'h000000}; // R8
          WLEN_16: hold_word_out <= {shift_reg[15:0], 16'h0000}; // R8
          WLEN_24: hold_word_out <= {shift_reg[23:0], 8'h00}; // R8
          default: hold_word_out <= shift_reg; // R6
        endcase
      end
    end else begin
      word_load_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_out <= 1'b0;
    end else if (clk_en_in) begin
      busy_out <= (state == SFWL_IDLE) ? word_sync_in : (state == SFWL_SHIFT);
    end
  end

  a_sync_starts_shift: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (clk_en_in && state == SFWL_IDLE && word_sync_in) |=> (state == SFWL_SHIFT)) // R5
    else $error("sync did not start shifting");
  a_count_loaded: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (clk_en_in && state == SFWL_IDLE && word_sync_in) |=> (bit_cnt == $past(next_bit_cnt))) // R5
    else $error("down-counter not loaded with word length");
  a_xfer_after_last: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (clk_en_in && state == SFWL_SHIFT && bit_cnt == 6'h01) |=> (state == SFWL_XFER)) // R6
    else $error("no transfer after last bit");
  a_shift_rearm: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (clk_en_in && state == SFWL_XFER) |=> (state == SFWL_IDLE)) // R7
    else $error("shifter not re-enabled after transfer");
  a_shift_bit_in: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (clk_en_in && state == SFWL_SHIFT) |=> (shift_reg[0] == $past(ser_data_in))) // R3
    else $error("serial bit not sampled");
  a_load_pulse: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    word_load_out |-> !$past(word_load_out)) // R6
    else $error("load strobe longer than one cycle");
  a_short_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (word_load_out && word_len_in == WLEN_8 && $stable(word_len_in))
      |-> (hold_word_out[23:0] == 24'h000000)) // R8
    else $error("low bits of short word not zero");
endmodule

// >>> core/sfwl_pkg.sv
// constants shared by the serial frequency word loader
package sfwl_pkg;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned CNT_W       = 6;
  localparam int unsigned WLEN_W      = 2;
  // word length select encoding: 0=8, 1=16, 2=24, 3=32 bits
  localparam logic [1:0] WLEN_8      = 2'h0;
  localparam logic [1:0] WLEN_16     = 2'h1;
  localparam logic [1:0] WLEN_24     = 2'h2;
  localparam logic [1:0] WLEN_32     = 2'h3;
  localparam logic [1:0] WLEN_RST    = 2'h3;
  localparam logic [5:0] BITS_PER_STEP = 6'h08;
  localparam logic [31:0] HOLD_RST   = 32'h0000_0000;
  localparam logic [31:0] SHIFT_RST  = 32'h0000_0000;
  localparam logic [5:0]  CNT_RST    = 6'h00;
  typedef enum logic [1:0] {
    SFWL_IDLE  = 2'b00,
    SFWL_SHIFT = 2'b01,
    SFWL_XFER  = 2'b11
  } sfwl_state_e;
endpackage

// >>> core/sfwl_top.sv
// serial frequency word loader: carrier and sample offset ports
`timescale 1ns/100ps
// Functional notes
// R1 - two independent serial ports: carrier offset and sample offset words
// R2 - word length 8, 16, 24 or 32 bits from a configuration field
// R3 - serial data pin sampled into a shift register each rising edge
// R4 - sender raises sync one clock before the first data bit
// R5 - sync loads down-counter with length; one bit shifted per clock
// R6 - after last bit, shifting stops and word copies to 32-bit holding register
// R7 - shift register re-enabled the cycle after the transfer
// R8 - short words land in the upper bits, low bits zeroed
// R9 - sender transmits most significant bit first
// R10 - sender holds sync for at most one clock per word
// R11 - each port has own shift, counter and holding register
module sfwl_top (
  input  wire logic                        core_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        clk_en_in,
  input  wire logic [sfwl_pkg::WLEN_W-1:0] word_len_sel_in,
  input  wire logic                        carrier_offset_serial_data_in,
  input  wire logic                        carrier_offset_word_sync_in,
  input  wire logic                        sample_offset_serial_data_in,
  input  wire logic                        sample_offset_word_sync_in,
  output logic [sfwl_pkg::WORD_W-1:0]      carrier_offset_word_out,
  output logic                             carrier_offset_load_out,
  output logic                             carrier_offset_busy_out,
  output logic [sfwl_pkg::WORD_W-1:0]      sample_offset_word_out,
  output logic                             sample_offset_load_out,
  output logic                             sample_offset_busy_out
);
  import sfwl_pkg::*;

  // pins come from an outside device: two stages before use
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [WLEN_W-1:0] wlen;

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else if (clk_en_in) begin
      pin_meta <= {sample_offset_word_sync_in, sample_offset_serial_data_in,
                   carrier_offset_word_sync_in, carrier_offset_serial_data_in};
      pin_sync <= pin_meta;
    end
  end

  // length register; same delay on both ports so words stay aligned
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wlen <= WLEN_RST;
    end else if (clk_en_in) begin
      wlen <= word_len_sel_in; // R2
    end
  end

  // separate instances keep the ports fully independent
  sfwl_port u_carrier ( // R1 R11
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .word_len_in   (wlen),
    .ser_data_in   (pin_sync[0]),
    .word_sync_in  (pin_sync[1]),
    .hold_word_out (carrier_offset_word_out),
    .word_load_out (carrier_offset_load_out),
    .busy_out      (carrier_offset_busy_out)
  );

  sfwl_port u_sample ( // R1 R11
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .word_len_in   (wlen),
    .ser_data_in   (pin_sync[2]),
    .word_sync_in  (pin_sync[3]),
    .hold_word_out (sample_offset_word_out),
    .word_load_out (sample_offset_load_out),
    .busy_out      (sample_offset_busy_out)
  );

  a_ports_apart: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (carrier_offset_load_out && !sample_offset_busy_out && !$past(sample_offset_load_out))
      |=> $stable(sample_offset_word_out)) // R11
    else $error("carrier load disturbed sample port");
endmodule

// >>> test/sfwl_sender.sv
// behavioural tracking-loop sender for one serial frequency port
`timescale 1ns/100ps
module sfwl_sender (
  input  wire logic        core_clk_in,
  input  wire logic        go_in,
  input  wire logic [31:0] word_in,
  input  wire logic [5:0]  bits_in,
  output logic             sync_out,
  output logic             data_out,
  output logic             idle_out
);
  logic [31:0] sr;
  logic [5:0]  left;
  initial begin
    sync_out = 1'b0;
    data_out = 1'b0;
    sr = 32'h0;
    left = 6'h00;
  end
  // one spare cycle after the last bit: a sync there would be lost
  assign idle_out = (left == 6'h00) && !sync_out;
  always @(posedge core_clk_in) begin
    sync_out <= 1'b0;
    if (go_in && idle_out) begin
      sync_out <= 1'b1;
      sr <= word_in;
      left <= bits_in + 6'h01;
      data_out <= ~data_out;
    end else if (left > 6'h01) begin
      data_out <= sr[31];
      sr <= {sr[30:0], 1'b0};
      left <= left - 6'h01;
    end else begin
      // released line toggles so no stale bit looks valid
      data_out <= ~data_out;
      left <= 6'h00;
    end
  end
endmodule

// >>> test/sfwl_top_tb.sv
// self-checking bench for the serial frequency word loader
`timescale 1ns/100ps
module sfwl_top_tb;
  import sfwl_pkg::*;
  logic        core_clk_in, sys_rst_in, clk_en_in;
  logic [1:0]  word_len_sel_in;
  logic        co_go, so_go, co_sync, co_data, so_sync, so_data, co_idle, so_idle;
  logic [31:0] co_w, so_w, co_word, so_word;
  logic        co_load, so_load, co_busy, so_busy;
  logic [5:0]  nbits;
  logic [31:0] co_q[$];
  logic [31:0] so_q[$];
  int          err_total, comparisons, n;
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  sfwl_sender co_snd (.core_clk_in(core_clk_in), .go_in(co_go), .word_in(co_w),
    .bits_in(nbits), .sync_out(co_sync), .data_out(co_data), .idle_out(co_idle));
  sfwl_sender so_snd (.core_clk_in(core_clk_in), .go_in(so_go), .word_in(so_w),
    .bits_in(nbits), .sync_out(so_sync), .data_out(so_data), .idle_out(so_idle));
  sfwl_top sfwl_top_inst (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .word_len_sel_in(word_len_sel_in),
    .carrier_offset_serial_data_in(co_data), .carrier_offset_word_sync_in(co_sync),
    .sample_offset_serial_data_in(so_data), .sample_offset_word_sync_in(so_sync),
    .carrier_offset_word_out(co_word), .carrier_offset_load_out(co_load),
    .carrier_offset_busy_out(co_busy), .sample_offset_word_out(so_word),
    .sample_offset_load_out(so_load), .sample_offset_busy_out(so_busy));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // note expected words as the sender accepts them; short words keep only top bits
  always @(posedge core_clk_in) begin
    if (co_go && co_idle) begin
      co_q.push_back(co_w & ~(32'hffffffff >> nbits));
      co_w <= $urandom;
    end
    if (so_go && so_idle) begin
      so_q.push_back(so_w & ~(32'hffffffff >> nbits));
      so_w <= $urandom;
    end
  end
  always @(posedge core_clk_in) begin
    if (co_load === 1'b1) chk("carrier word", co_q.size() ? co_q.pop_front() : 'x, co_word);
    if (so_load === 1'b1) chk("sample word", so_q.size() ? so_q.pop_front() : 'x, so_word);
    // shifting has stopped by the time the new word stands
    if (co_load === 1'b1) chk("carrier busy", 32'h0, {31'h0, co_busy});
    if (so_load === 1'b1) chk("sample busy", 32'h0, {31'h0, so_busy});
  end
  initial begin
    void'($urandom(32'h6c86900c));
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    word_len_sel_in = 2'h3;
    nbits = 6'h20;
    co_go = 1'b0;
    so_go = 1'b0;
    co_w = $urandom;
    so_w = $urandom;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    chk("carrier reset", 32'h0, co_word);
    chk("sample reset", 32'h0, so_word);
    for (int s = 0; s < 4; s++) begin
      word_len_sel_in <= s[1:0];
      nbits <= 6'((s + 1) * 8);
      repeat (4) @(posedge core_clk_in);
      // carrier back to back, sample at random spacing
      for (int c = 0; c < 200; c++) begin
        co_go <= 1'b1;
        so_go <= 1'($urandom_range(0, 1));
        @(posedge core_clk_in);
      end
      co_go <= 1'b0;
      so_go <= 1'b0;
      n = 0;
      while ((co_q.size() || so_q.size()) && n < 300) begin
        @(posedge core_clk_in);
        n++;
      end
      if (n >= 300) begin
        err_total++;
        $display("wrong value words pending expected 0 seen %0d", co_q.size() + so_q.size());
        results();
      end
      $display("test word length %0d done", (s + 1) * 8);
    end
    results();
  end
endmodule
